// >>> pkg/iec_pkg.sv
// Purpose: Constants and types of the 16-bit interval/event counter.
// Assumes: Word registers on a plain 4-bit address, 16-bit data port.
// Notes:   Eight-bit control registers sit in the low data bits.
package iec_pkg;
  localparam int DW = 16;
  localparam int AW = 4;
  localparam int NUM_CH = 3;
  // Register addresses.
  localparam logic [AW-1:0] ADDR_CTL0     = 4'h0;
  localparam logic [AW-1:0] ADDR_CTL1     = 4'h1;
  localparam logic [AW-1:0] ADDR_PIN_CTL  = 4'h2;
  localparam logic [AW-1:0] ADDR_EDGE_CTL = 4'h3;
  localparam logic [AW-1:0] ADDR_OPTION   = 4'h4;
  localparam logic [AW-1:0] ADDR_PERIOD   = 4'h5;
  localparam logic [AW-1:0] ADDR_CH1      = 4'h6;
  localparam logic [AW-1:0] ADDR_COUNT    = 4'h9;
  localparam logic [AW-1:0] ADDR_IRQ_STAT = 4'ha;
  localparam logic [AW-1:0] ADDR_IRQ_MASK = 4'hb;
  // Field positions.
  localparam int CTL0_CE_BIT  = 7;
  localparam int CTL0_CKS_LSB = 0;
  localparam int CTL1_EEE_BIT = 5;
  localparam int CTL1_MD_LSB  = 0;
  localparam int EDGE_EES_LSB = 2;
  localparam int OPT_OVF_BIT  = 0;
  // Reset values and counter limits.
  localparam logic [7:0]    CTL_RESET = 8'h00;
  localparam logic [DW-1:0] CNT_MAX   = 16'hffff;
  localparam logic [DW-1:0] CNT_ZERO  = 16'h0000;
  localparam logic [DW-1:0] CNT_ONE   = 16'h0001;
  localparam logic [6:0]    PRE_ONE   = 7'h01;

  typedef enum logic [2:0] {
    MODE_INTERVAL = 3'b000,
    MODE_EVENT    = 3'b001
  } iec_mode_t;

  typedef enum logic [1:0] {
    EDGE_NONE    = 2'b00,
    EDGE_RISING  = 2'b01,
    EDGE_FALLING = 2'b10,
    EDGE_BOTH    = 2'b11
  } iec_edge_t;

  typedef enum logic [1:0] {
    RUN_IDLE  = 2'b00,
    RUN_ARMED = 2'b01,
    RUN_COUNT = 2'b10
  } iec_run_t;

  // Event layout shared by the interrupt status and mask registers.
  typedef struct packed {
    logic       ovf;
    logic [2:0] ch;
    logic       per;
  } iec_evt_t;
endpackage : iec_pkg

// >>> rtl/iec_counter.sv
// Purpose: 16-bit period counter with three channel compares and
//          an external event count mode.
// Assumes: One clock; event input is asynchronous to it.
// Notes:   Pin outputs are registered; idle levels come from the
//          output level bits.
`timescale 1ns/1ps
module iec_counter (
  // Clock, reset and enable.
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  // Register port.
  input  wire logic [iec_pkg::AW-1:0]   i_addr,
  input  wire logic [iec_pkg::DW-1:0]   i_wdata,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  output logic      [iec_pkg::DW-1:0]   o_rdata,
  // External event pin.
  input  wire logic                     i_event,
  // Timer pins, bit 0 is the period output.
  output logic      [iec_pkg::NUM_CH:0] o_timer_out,
  // Interrupt.
  output logic                          o_irq
);
  localparam int NCH = iec_pkg::NUM_CH;
  localparam logic [6:0] PRE_ONE_W = iec_pkg::PRE_ONE;

  logic [7:0]                 ctl0;
  logic [7:0]                 ctl1;
  logic [7:0]                 pin_ctl;
  logic [3:0]                 edge_ctl;
  logic                       ovf_flag;
  logic [iec_pkg::DW-1:0]     per_reg;
  logic [iec_pkg::DW-1:0]     ch_reg  [NCH];
  logic [iec_pkg::DW-1:0]     per_buf;
  logic [iec_pkg::DW-1:0]     ch_buf  [NCH];
  logic [iec_pkg::DW-1:0]     cnt;
  logic [iec_pkg::DW-1:0]     next_cnt;
  iec_pkg::iec_run_t          run_st;
  iec_pkg::iec_evt_t          irq_stat;
  iec_pkg::iec_evt_t          irq_mask;
  iec_pkg::iec_evt_t          evt;
  iec_pkg::iec_mode_t         mode;
  iec_pkg::iec_edge_t         edge_sel;
  logic [6:0]                 pre_cnt;
  logic [6:0]                 pre_mask;
  logic                       evt_s1;
  logic                       evt_s2;
  logic                       evt_d;
  logic                       evt_edge;
  logic                       pre_tick;
  logic                       tick;
  logic                       bus_wr;
  logic                       bus_rd;
  logic                       ce_bit;
  logic                       mode_ok;
  logic                       event_mode;
  logic                       start;
  logic                       per_hit;
  logic                       ovf_hit;
  logic [NCH-1:0]             ch_hit;
  logic                       per_tog;
  logic [NCH-1:0]             ch_tog;
  logic [NCH:0]               pin_wave;
  logic [iec_pkg::DW-1:0]     next_rdata;

  // Bus strobes are frozen along with everything else.
  assign bus_wr     = i_wr & i_ce;
  assign bus_rd     = i_rd & i_ce;
  assign ce_bit     = ctl0[iec_pkg::CTL0_CE_BIT];
  assign mode       = iec_pkg::iec_mode_t'(ctl1[iec_pkg::CTL1_MD_LSB +: 3]);
  assign edge_sel   =
    iec_pkg::iec_edge_t'(edge_ctl[iec_pkg::EDGE_EES_LSB +: 2]);
  assign event_mode = (mode == iec_pkg::MODE_EVENT);
  assign mode_ok    = (mode == iec_pkg::MODE_INTERVAL) || event_mode;
  assign start      = (run_st == iec_pkg::RUN_IDLE) && ce_bit && mode_ok;

  // Control registers; in event mode the pin enables cannot be set.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ctl0     <= iec_pkg::CTL_RESET;
      ctl1     <= iec_pkg::CTL_RESET;
      pin_ctl  <= iec_pkg::CTL_RESET;
      edge_ctl <= iec_pkg::CTL_RESET[3:0];
    end else if (bus_wr) begin
      case (i_addr)
        iec_pkg::ADDR_CTL0: begin
          ctl0 <= i_wdata[7:0] & 8'h87;
        end
        iec_pkg::ADDR_CTL1: begin
          ctl1 <= i_wdata[7:0] & 8'h27;
        end
        iec_pkg::ADDR_PIN_CTL: begin
          pin_ctl <= event_mode ? (i_wdata[7:0] & 8'haa)
                                : i_wdata[7:0];
        end
        iec_pkg::ADDR_EDGE_CTL: begin
          edge_ctl <= i_wdata[3:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Compare registers; the period and channel writes go to the
  // buffers at once, so a smaller period while counting can overflow.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_reg <= iec_pkg::CNT_ZERO;
      per_buf <= iec_pkg::CNT_ZERO;
      for (int k = 0; k < NCH; k++) begin
        ch_reg[k] <= iec_pkg::CNT_ZERO;
        ch_buf[k] <= iec_pkg::CNT_ZERO;
      end
    end else if (i_ce) begin
      if (start) begin
        per_buf <= per_reg;
        for (int k = 0; k < NCH; k++) begin
          ch_buf[k] <= ch_reg[k];
        end
      end
      if (bus_wr && i_addr == iec_pkg::ADDR_PERIOD) begin
        per_reg <= i_wdata;
        per_buf <= i_wdata;
      end
      for (int k = 0; k < NCH; k++) begin
        if (bus_wr && i_addr == iec_pkg::ADDR_CH1 + 4'(k)) begin
          ch_reg[k] <= i_wdata;
          ch_buf[k] <= i_wdata;
        end
      end
    end
  end

  // Event pin synchroniser and edge detector behind the second stage.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      evt_s1 <= 1'b0;
      evt_s2 <= 1'b0;
      evt_d  <= 1'b0;
    end else if (i_ce) begin
      evt_s1 <= i_event;
      evt_s2 <= evt_s1;
      evt_d  <= evt_s2;
    end
  end

  // Valid edge decode.
  always_comb begin
    case (edge_sel)
      iec_pkg::EDGE_RISING:  evt_edge = evt_s2 & ~evt_d;
      iec_pkg::EDGE_FALLING: evt_edge = ~evt_s2 & evt_d;
      iec_pkg::EDGE_BOTH:    evt_edge = evt_s2 ^ evt_d;
      default:               evt_edge = 1'b0;
    endcase
  end

  // Prescaler divides by two to the power of the select field.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pre_cnt <= 7'h00;
    end else if (i_ce) begin
      pre_cnt <= pre_cnt + PRE_ONE_W;
    end
  end
  assign pre_mask = (PRE_ONE_W << ctl0[iec_pkg::CTL0_CKS_LSB +: 3])
                    - PRE_ONE_W;
  assign pre_tick = ((pre_cnt & pre_mask) == pre_mask);

  // Count clock: edges in event mode or when chosen as interval clock.
  assign tick = i_ce && (run_st != iec_pkg::RUN_IDLE) &&
                ((event_mode || ctl1[iec_pkg::CTL1_EEE_BIT]) ? evt_edge
                                                              : pre_tick);

  // The first tick only brings the counter from FFFFH to zero.
  always_comb begin
    if (run_st == iec_pkg::RUN_ARMED) begin
      next_cnt = iec_pkg::CNT_ZERO;
    end else if (cnt == per_buf) begin
      next_cnt = iec_pkg::CNT_ZERO;
    end else begin
      next_cnt = cnt + iec_pkg::CNT_ONE;
    end
  end

  // A match at FFFFH is a period clear, never an overflow.
  assign per_hit = tick && (run_st == iec_pkg::RUN_COUNT) &&
                   (cnt == per_buf);
  assign ovf_hit = tick && (run_st == iec_pkg::RUN_COUNT) &&
                   (cnt == iec_pkg::CNT_MAX) && !per_hit;
  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      ch_hit[k] = tick && (next_cnt == ch_buf[k]);
    end
  end

  // Run sequencing; clearing the enable parks the counter at FFFFH.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      run_st <= iec_pkg::RUN_IDLE;
    end else if (i_ce) begin
      case (run_st)
        iec_pkg::RUN_IDLE: begin
          if (start) begin
            run_st <= iec_pkg::RUN_ARMED;
          end
        end
        iec_pkg::RUN_ARMED: begin
          if (!ce_bit || !mode_ok) begin
            run_st <= iec_pkg::RUN_IDLE;
          end else if (tick) begin
            run_st <= iec_pkg::RUN_COUNT;
          end
        end
        iec_pkg::RUN_COUNT: begin
          if (!ce_bit || !mode_ok) begin
            run_st <= iec_pkg::RUN_IDLE;
          end
        end
        default: begin
          run_st <= iec_pkg::RUN_IDLE;
        end
      endcase
    end
  end

  // Counter proper.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt <= iec_pkg::CNT_MAX;
    end else if (i_ce) begin
      if (run_st == iec_pkg::RUN_IDLE) begin
        cnt <= iec_pkg::CNT_MAX;
      end else if (tick) begin
        cnt <= next_cnt;
      end
    end
  end

  // Toggle flops for the period and channel square waves.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      per_tog <= 1'b0;
      ch_tog  <= '0;
    end else if (i_ce) begin
      if (per_hit) begin
        per_tog <= ~per_tog;
      end
      ch_tog <= ch_tog ^ ch_hit;
    end
  end

  // Pins show the wave when enabled outside event mode, else the idle level bit.
  // Packing the waves keeps every pin index inside its vector.
  assign pin_wave = {ch_tog, per_tog};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_timer_out <= '0;
    end else if (i_ce) begin
      for (int k = 0; k <= NCH; k++) begin
        if (pin_ctl[2*k] && !event_mode) begin
          o_timer_out[k] <= pin_wave[k];
        end else begin
          o_timer_out[k] <= pin_ctl[2*k+1];
        end
      end
    end
  end

  // Overflow flag: software clears by writing zero; a set wins.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ovf_flag <= 1'b0;
    end else if (ovf_hit) begin
      ovf_flag <= 1'b1;
    end else if (bus_wr && i_addr == iec_pkg::ADDR_OPTION &&
                 !i_wdata[iec_pkg::OPT_OVF_BIT]) begin
      ovf_flag <= 1'b0;
    end
  end

  // Sticky interrupt status, cleared by its read; new events win.
  assign evt = '{ovf: ovf_hit, ch: ch_hit, per: per_hit};
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      irq_stat <= '0;
      irq_mask <= '0;
    end else if (i_ce) begin
      if (bus_rd && i_addr == iec_pkg::ADDR_IRQ_STAT) begin
        irq_stat <= evt;
      end else begin
        irq_stat <= irq_stat | evt;
      end
      if (bus_wr && i_addr == iec_pkg::ADDR_IRQ_MASK) begin
        irq_mask <= i_wdata[4:0];
      end
    end
  end
  assign o_irq = |(irq_stat & irq_mask);

  // Read mux; unmapped addresses read zero.
  always_comb begin
    next_rdata = '0;
    case (i_addr)
      iec_pkg::ADDR_CTL0:     next_rdata[7:0] = ctl0;
      iec_pkg::ADDR_CTL1:     next_rdata[7:0] = ctl1;
      iec_pkg::ADDR_PIN_CTL:  next_rdata[7:0] = pin_ctl;
      iec_pkg::ADDR_EDGE_CTL: next_rdata[3:0] = edge_ctl;
      iec_pkg::ADDR_OPTION:   next_rdata[0]   = ovf_flag;
      iec_pkg::ADDR_PERIOD:   next_rdata      = per_reg;
      iec_pkg::ADDR_COUNT:    next_rdata      = cnt;
      iec_pkg::ADDR_IRQ_STAT: next_rdata[4:0] = irq_stat;
      iec_pkg::ADDR_IRQ_MASK: next_rdata[4:0] = irq_mask;
      default: begin
        for (int k = 0; k < NCH; k++) begin
          if (i_addr == iec_pkg::ADDR_CH1 + 4'(k)) begin
            next_rdata = ch_reg[k];
          end
        end
      end
    endcase
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rdata <= '0;
    end else if (i_ce) begin
      o_rdata <= bus_rd ? next_rdata : '0;
    end
  end

  // Checks on the counter behaviour.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  chk_per_zero_hold: assert property (
    (run_st == iec_pkg::RUN_COUNT && per_buf == iec_pkg::CNT_ZERO)
      |-> cnt == iec_pkg::CNT_ZERO)
    else $error("Counter left zero with period zero.");
  chk_per_match_clear: assert property (
    per_hit |=> (cnt == iec_pkg::CNT_ZERO) && per_tog != $past(per_tog))
    else $error("Period match did not clear and toggle.");
  chk_wrap_no_ovf: assert property (
    (tick && run_st == iec_pkg::RUN_COUNT && cnt == iec_pkg::CNT_MAX &&
     per_buf == iec_pkg::CNT_MAX) |-> per_hit && !ovf_hit)
    else $error("Wrap at full period raised overflow.");
  chk_per_write_buf: assert property (
    (bus_wr && i_addr == iec_pkg::ADDR_PERIOD) |=> per_buf == $past(i_wdata))
    else $error("Period write missed the buffer.");
  chk_ch_toggle: assert property (
    ch_hit[0] |=> ch_tog[0] != $past(ch_tog[0]))
    else $error("Channel match did not toggle.");
  chk_ch_no_match: assert property (
    (i_ce && !ch_hit[0]) |=> $stable(ch_tog[0]))
    else $error("Channel toggled without a match.");
  chk_start_load: assert property (
    (i_ce && start && !(bus_wr && i_addr == iec_pkg::ADDR_PERIOD))
      |=> per_buf == $past(per_reg) && cnt == iec_pkg::CNT_MAX
          && run_st == iec_pkg::RUN_ARMED)
    else $error("Enable did not load the period buffer.");
  chk_event_pins_off: assert property (
    (i_ce && event_mode) |=> o_timer_out ==
      {$past(pin_ctl[7]), $past(pin_ctl[5]), $past(pin_ctl[3]),
       $past(pin_ctl[1])})
    else $error("Timer pin driven in event mode.");
  chk_event_tick: assert property (
    (event_mode && !evt_edge) |-> !tick)
    else $error("Event mode counted without a valid edge.");

  cov_per_zero: cover property (per_hit && per_buf == iec_pkg::CNT_ZERO);
  cov_overflow: cover property (ovf_hit);
  cov_ch_match: cover property (ch_hit[0] ##[1:64] per_hit);
  cov_event_match: cover property (event_mode && per_hit);
endmodule : iec_counter

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the 16-bit interval/event counter.
// Assumes: Register map, field positions and tick timing as handed over.
// Notes:   Waveform checks measure toggle spacing, so start-up latency
//          of a cycle or two does not disturb them.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_fail++; \
      $display("wrong value %s exp %0h got %0h", nm, exp, got); \
    end \
  end
module tb_top;
  logic                     i_clk;
  logic                     i_rst_b;
  logic                     i_ce;
  logic [iec_pkg::AW-1:0]   i_addr;
  logic [iec_pkg::DW-1:0]   i_wdata;
  logic                     i_wr;
  logic                     i_rd;
  logic [iec_pkg::DW-1:0]   o_rdata;
  logic                     i_event;
  logic [iec_pkg::NUM_CH:0] o_timer_out;
  logic                     o_irq;
  int                       num_checks;
  int                       n_fail;
  logic [15:0]              d;
  int                       n;

  iec_counter dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_event(i_event), .o_timer_out(o_timer_out), .o_irq(o_irq)
  );

  // Free-running 20 MHz clock.
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // One-cycle write strobe, changed just after the edge.
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe is taken.
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd

  // Edges from now until timer pin k changes, capped at lim.
  task automatic wait_tog(input int k, input int lim, output int c);
    logic v;
    #1 v = o_timer_out[k];
    c = 0;
    while (c < lim && o_timer_out[k] === v) begin
      @(posedge i_clk);
      #1 c++;
    end
  endtask : wait_tog

  // Drive the event pin and give the synchroniser time to settle.
  task automatic ev(input logic v);
    @(posedge i_clk);
    i_event <= v;
    repeat (6) @(posedge i_clk);
  endtask : ev

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  // Watchdog sized above the longest wrap test of 65536 ticks.
  initial begin
    repeat (95000) @(posedge i_clk);
    n_fail++;
    final_report();
  end

  // Main sequence.
  initial begin
    logic [3:0]  ra[6];
    logic [15:0] rv[6];
    logic [15:0] evc[7];
    logic [1:0]  inc_r[4];
    logic [1:0]  inc_f[4];
    ra = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hc};
    rv = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000};
    evc = '{16'h0000, 16'h0001, 16'h0002, 16'h0000, 16'h0001, 16'h0002,
            16'h0000};
    inc_r = '{2'd0, 2'd1, 2'd0, 2'd1};
    inc_f = '{2'd0, 2'd0, 2'd1, 2'd1};
    num_checks = 0;
    n_fail = 0;
    i_rst_b = 1'b0;
    i_ce = 1'b1;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_event = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_b <= 1'b1;
    `CHK("pins at reset", 4'h0, o_timer_out);
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], d);
      `CHK("reset read", rv[i], d);
    end
    $display("test reset done");

    // Period zero: stays at zero, pin 0 flips every tick.
    wr(iec_pkg::ADDR_PIN_CTL, 16'h0009);
    wr(iec_pkg::ADDR_IRQ_MASK, 16'h0001);
    wr(iec_pkg::ADDR_PERIOD, 16'h0000);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    repeat (10) @(posedge i_clk);
    wait_tog(0, 20, n);
    wait_tog(0, 20, n);
    `CHK("zero period gap", 1, n);
    rd(iec_pkg::ADDR_COUNT, d);
    `CHK("zero period count", 16'h0000, d);
    `CHK("disabled pin idle", 1'b1, o_timer_out[1]);
    `CHK("period irq", 1'b1, o_irq);
    // A low clock enable must freeze the running wave.
    @(posedge i_clk);
    i_ce <= 1'b0;
    wait_tog(0, 5, n);
    `CHK("frozen pin", 5, n);
    @(posedge i_clk);
    i_ce <= 1'b1;
    $display("test period zero done");

    // Lowering the period below the count defers the match past wrap.
    wr(iec_pkg::ADDR_CTL0, 16'h0000);
    wr(iec_pkg::ADDR_PERIOD, 16'h0040);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    repeat (48) @(posedge i_clk);
    wr(iec_pkg::ADDR_PERIOD, 16'h0010);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    repeat (100) @(posedge i_clk);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    `CHK("no early match", 1'b0, d[0]);
    rd(iec_pkg::ADDR_COUNT, d);
    `CHK("count past new period", 1'b1, d > 16'h0010);
    @(posedge i_clk);
    #1;
    `CHK("read data cleared", 16'h0000, o_rdata);
    $display("test period lowered done");

    // Channels 1 and 2 inside the period, channel 3 beyond it.
    wr(iec_pkg::ADDR_CTL0, 16'h0000);
    wr(iec_pkg::ADDR_PERIOD, 16'h0007);
    for (int k = 0; k < 3; k++)
      wr(iec_pkg::ADDR_CH1 + 4'(k), 16'(3 + 4 * k));
    wr(iec_pkg::ADDR_PIN_CTL, 16'h0055);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    for (int k = 0; k < 3; k++) begin
      wait_tog(k, 40, n);
      wait_tog(k, 40, n);
      `CHK("toggle gap", 8, n);
    end
    wait_tog(3, 40, n);
    `CHK("channel 3 still", 40, n);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    `CHK("channel status", 16'h0007, d);
    wr(iec_pkg::ADDR_IRQ_MASK, 16'h0008);
    repeat (20) @(posedge i_clk);
    `CHK("channel 3 irq", 1'b0, o_irq);
    wr(iec_pkg::ADDR_IRQ_MASK, 16'h0002);
    repeat (10) @(posedge i_clk);
    `CHK("channel 1 irq", 1'b1, o_irq);
    $display("test channels done");

    // Full-range period wraps with a match but no overflow.
    wr(iec_pkg::ADDR_CTL0, 16'h0000);
    wr(iec_pkg::ADDR_PERIOD, 16'hffff);
    wr(iec_pkg::ADDR_IRQ_MASK, 16'h0011);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    wait_tog(0, 70000, n);
    `CHK("wrap in range", 1'b1, n > 65525 && n < 65545);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    `CHK("wrap match", 2'b01, {d[4], d[0]});
    rd(iec_pkg::ADDR_OPTION, d);
    `CHK("overflow flag", 1'b0, d[0]);
    $display("test full period done");

    // Event mode: count rising edges, match every period + 1 edges.
    wr(iec_pkg::ADDR_CTL0, 16'h0000);
    wr(iec_pkg::ADDR_CTL1, 16'h0001);
    wr(iec_pkg::ADDR_PIN_CTL, 16'h0055);
    rd(iec_pkg::ADDR_PIN_CTL, d);
    `CHK("pin enables off", 16'h0000, d);
    wr(iec_pkg::ADDR_PERIOD, 16'h0002);
    wr(iec_pkg::ADDR_EDGE_CTL, 16'h0004);
    wr(iec_pkg::ADDR_IRQ_MASK, 16'h0001);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    rd(iec_pkg::ADDR_IRQ_STAT, d);
    for (int i = 0; i < 7; i++) begin
      ev(1'b1);
      ev(1'b0);
      rd(iec_pkg::ADDR_COUNT, d);
      `CHK("event count", evc[i], d);
      `CHK("event irq", i == 3 || i == 6, o_irq);
      rd(iec_pkg::ADDR_IRQ_STAT, d);
    end
    `CHK("event pins", 4'h0, o_timer_out);
    $display("test event count done");

    // Every edge code, checked on each half of a pulse.
    // The period sits well above the few edges counted here.
    wr(iec_pkg::ADDR_PERIOD, 16'h0010);
    for (int e = 0; e < 4; e++) begin
      wr(iec_pkg::ADDR_CTL0, 16'h0000);
      wr(iec_pkg::ADDR_EDGE_CTL, 16'(e << iec_pkg::EDGE_EES_LSB));
      wr(iec_pkg::ADDR_CTL0, 16'h0080);
      ev(1'b1);
      ev(1'b0);
      rd(iec_pkg::ADDR_COUNT, n[15:0]);
      ev(1'b1);
      rd(iec_pkg::ADDR_COUNT, d);
      `CHK("rise step", 16'(n[15:0] + inc_r[e]), d);
      ev(1'b0);
      rd(iec_pkg::ADDR_COUNT, d);
      `CHK("fall step", 16'(n[15:0] + inc_r[e] + inc_f[e]), d);
    end
    $display("test edge select done");

    // Interval mode clocked by event edges still drives the pin.
    wr(iec_pkg::ADDR_CTL0, 16'h0000);
    wr(iec_pkg::ADDR_CTL1, 16'h0020);
    wr(iec_pkg::ADDR_PERIOD, 16'h0001);
    wr(iec_pkg::ADDR_EDGE_CTL, 16'h0004);
    wr(iec_pkg::ADDR_PIN_CTL, 16'h0001);
    wr(iec_pkg::ADDR_CTL0, 16'h0080);
    ev(1'b1);
    ev(1'b0);
    #1 d[0] = o_timer_out[0];
    for (int i = 0; i < 2; i++) begin
      ev(1'b1);
      ev(1'b0);
      #1;
      `CHK("event clock pin", d[0] ^ i[0], o_timer_out[0]);
    end
    $display("test event clock done");
    final_report();
  end
endmodule : tb_top
